/* logic/ipf_top.sv */
// Notes on behaviour
// - three-bit field, code 111 means level 7
// - code 001 is level 1, codes map binary
// - code 000 disables source, never forwarded
// - gap bits always read as zero
// - ctrl1 bits 10-8 output compare 2 level
// - ctrl1 bits 6-4 input capture 2 level
// - ctrl1 bits 2-0 dma channel 0 level
// - ctrl2 bits 10-8 spi1 event level
// - reset loads level 4, gaps zero
// - ctrl1 bits 14-12 timer 2 level
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ipf_top
	import ipf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] src_req,
	output ipf_src_t [7:0] src_fwd,
	output logic [2:0] timer2_prio,
	output logic [2:0] outcmp2_prio,
	output logic [2:0] incap2_prio,
	output logic [2:0] dma_ch0_done_prio,
	output logic [2:0] uart1_rx_prio,
	output logic [2:0] spi1_event_prio,
	output logic [2:0] spi1_error_prio,
	output logic [2:0] timer3_prio
);
	logic aw_held_reg;
	logic w_held_reg;
	logic [3:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic wr_fire;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic [15:0] ctrl1;
	logic [15:0] ctrl2;
	logic [15:0] fwd_bits;
	logic [7:0] req_s1_reg;
	logic [7:0] req_s2_reg;
	logic [2:0] lvl [IPF_NSRC];

	// address and data are caught independently, in either order
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_ctrl1 = wr_fire && awaddr_reg == IPF_OFS_CTRL1;
	assign wr_ctrl2 = wr_fire && awaddr_reg == IPF_OFS_CTRL2;

	// write address holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			awaddr_reg <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg <= {s_axi_awaddr[3:2], 2'b00};
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	// write data holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	// write response; read-only and unmapped offsets answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= IPF_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_ctrl1 || wr_ctrl2) ? IPF_RESP_OKAY : IPF_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// the two priority registers
	ipf_prio_reg u_ctrl1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_ctrl1),
		.wdata(wdata_reg),
		.wstrb(wstrb_reg),
		.value(ctrl1)
	);

	ipf_prio_reg u_ctrl2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_ctrl2),
		.wdata(wdata_reg),
		.wstrb(wstrb_reg),
		.value(ctrl2)
	);

	// field extraction from the registers
	assign timer2_prio = ctrl1[IPF_POS_HI +: 3];
	assign outcmp2_prio = ctrl1[IPF_POS_MH +: 3];
	assign incap2_prio = ctrl1[IPF_POS_ML +: 3];
	assign dma_ch0_done_prio = ctrl1[IPF_POS_LO +: 3];
	assign uart1_rx_prio = ctrl2[IPF_POS_HI +: 3];
	assign spi1_event_prio = ctrl2[IPF_POS_MH +: 3];
	assign spi1_error_prio = ctrl2[IPF_POS_ML +: 3];
	assign timer3_prio = ctrl2[IPF_POS_LO +: 3];

	// source order: timer2, oc2, ic2, dma0, u1rx, spi1, spi1err, timer3
	assign lvl[0] = timer2_prio;
	assign lvl[1] = outcmp2_prio;
	assign lvl[2] = incap2_prio;
	assign lvl[3] = dma_ch0_done_prio;
	assign lvl[4] = uart1_rx_prio;
	assign lvl[5] = spi1_event_prio;
	assign lvl[6] = spi1_error_prio;
	assign lvl[7] = timer3_prio;

	// requests come from other peripherals' pins, so synchronise first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_s1_reg <= 8'h0;
			req_s2_reg <= 8'h0;
		end else begin
			req_s1_reg <= src_req;
			req_s2_reg <= req_s1_reg;
		end
	end

	// one gate per source; the arbiter downstream sees only enabled ones
	for (genvar i = 0; i < IPF_NSRC; i++) begin : g_src
		ipf_src_gate u_gate (
			.aclk(aclk),
			.aresetn(aresetn),
			.req_in(req_s2_reg[i]),
			.level(lvl[i]),
			.fwd(src_fwd[i])
		);
		assign fwd_bits[i] = src_fwd[i].req;
		assign fwd_bits[i + 8] = 1'b0;
	end

	// read path; one cycle after address taken
	assign s_axi_arready = !rvalid_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= IPF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= IPF_RESP_OKAY;
			unique case ({s_axi_araddr[3:2], 2'b00})
				IPF_OFS_CTRL1: rdata_reg <= {16'h0, ctrl1};
				IPF_OFS_CTRL2: rdata_reg <= {16'h0, ctrl2};
				IPF_OFS_REQS: rdata_reg <= {24'h0, req_s2_reg};
				IPF_OFS_FWD: rdata_reg <= {16'h0, fwd_bits};
				default: begin
					rdata_reg <= 32'h0;
					rresp_reg <= IPF_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// checks across the block
	reset_level_a: assert property (@(posedge aclk) $rose(aresetn) |-> ctrl1 == 16'h4444 && ctrl2 == 16'h4444)
		else $error("priority registers not at level 4 after reset");
	ctrl1_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b00 |=> s_axi_rdata[31:0] == {16'h0, $past(ctrl1)})
		else $error("ctrl1 readback wrong");
	timer2_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl1 && wstrb_reg[1] |=> timer2_prio == $past(wdata_reg[14:12]))
		else $error("timer2 level not from bits 14-12");
	spi1_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl2 && wstrb_reg[1] |=> spi1_event_prio == $past(wdata_reg[10:8]))
		else $error("spi1 event level not from bits 10-8");
	dma_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl1 && wstrb_reg[0] |=> dma_ch0_done_prio == $past(wdata_reg[2:0]) && incap2_prio == $past(wdata_reg[6:4]))
		else $error("low byte fields of ctrl1 wrong");
	timer3_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl2 && wstrb_reg[0] |=> timer3_prio == $past(wdata_reg[2:0]) && spi1_error_prio == $past(wdata_reg[6:4]))
		else $error("low byte fields of ctrl2 wrong");
	oc2_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl1 && wstrb_reg[1] |=> outcmp2_prio == $past(wdata_reg[10:8]))
		else $error("output compare 2 level not from bits 10-8");

	// write channel handshakes; readies stay low while a response is owed
	awready_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid_reg |-> !s_axi_awready)
		else $error("awready high while response pending");
	wready_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid_reg |-> !s_axi_wready)
		else $error("wready high while response pending");
	aw_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aw_held_reg |-> !s_axi_awready)
		else $error("awready high while address held");
	w_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		w_held_reg |-> !s_axi_wready)
		else $error("wready high while data held");
	fire_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> !aw_held_reg && !w_held_reg)
		else $error("held write not released");

	// write response; a slave answer must stand until taken
	bvalid_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid)
		else $error("no response after write");
	bvalid_stand_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	bvalid_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after bready");
	bresp_okay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && (wr_ctrl1 || wr_ctrl2) |=> s_axi_bresp == IPF_RESP_OKAY)
		else $error("register write not okay");
	bresp_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && !(wr_ctrl1 || wr_ctrl2) |=> s_axi_bresp == IPF_RESP_SLVERR)
		else $error("status write not refused");
	bad_write_inert_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && !(wr_ctrl1 || wr_ctrl2) |=> $stable(ctrl1) && $stable(ctrl2))
		else $error("refused write changed a register");

	// read channel; every offset of the window is mapped
	arready_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("arready high while read data pending");
	rvalid_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data after address");
	rvalid_stand_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	rvalid_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data held after rready");
	rresp_okay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rresp == IPF_RESP_OKAY)
		else $error("mapped read not okay");
	ctrl2_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b01 |=> s_axi_rdata == {16'h0, $past(ctrl2)})
		else $error("ctrl2 readback wrong");
	reqs_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b10 |=> s_axi_rdata == {24'h0, $past(req_s2_reg)})
		else $error("request status readback wrong");
	fwd_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'b11 |=> s_axi_rdata == {16'h0, $past(fwd_bits)})
		else $error("forwarded status readback wrong");
	rdata_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read half not zero");

	// register contents; gaps never hold a one, idle registers keep still
	ctrl1_gaps_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl1 & ~IPF_IMPL_MASK) == 16'h0)
		else $error("ctrl1 gap bit set");
	ctrl2_gaps_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl2 & ~IPF_IMPL_MASK) == 16'h0)
		else $error("ctrl2 gap bit set");
	ctrl1_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_ctrl1 |=> $stable(ctrl1))
		else $error("ctrl1 changed without write");
	ctrl2_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_ctrl2 |=> $stable(ctrl2))
		else $error("ctrl2 changed without write");
	uart1_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl2 && wstrb_reg[1] |=> uart1_rx_prio == $past(wdata_reg[14:12]))
		else $error("uart1 rx level not from bits 14-12");

	// reset values; checked while reset is held, so no disable here
	ctrl1_reset_a: assert property (@(posedge aclk) !aresetn |=> ctrl1 == IPF_RESET_VAL)
		else $error("ctrl1 not reset to level 4");
	ctrl2_reset_a: assert property (@(posedge aclk) !aresetn |=> ctrl2 == IPF_RESET_VAL)
		else $error("ctrl2 not reset to level 4");
	fwd_reset_a: assert property (@(posedge aclk) !aresetn |=> src_fwd == '0)
		else $error("forwarded requests not cleared by reset");

	// source path; the first edge after reset still shows reset values
	sync_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> req_s2_reg == $past(req_s1_reg))
		else $error("request synchroniser skipped a stage");
	fwd_bits_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fwd_bits[15:8] == 8'h0)
		else $error("forwarded status upper bits set");
	timer2_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> src_fwd[0].level == $past(timer2_prio))
		else $error("timer2 forwarded level wrong");
	timer3_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> src_fwd[7].level == $past(timer3_prio))
		else $error("timer3 forwarded level wrong");
	timer2_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(timer2_prio) == IPF_LVL_OFF |-> !src_fwd[0].req)
		else $error("disabled timer2 forwarded");
	timer3_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(timer3_prio) == IPF_LVL_OFF |-> !src_fwd[7].req)
		else $error("disabled timer3 forwarded");
endmodule : ipf_top
`default_nettype wire

/* logic/ipf_pkg.sv */
package ipf_pkg;
	// register byte addresses on the bus
	localparam logic [3:0] IPF_OFS_CTRL1 = 4'h0;
	localparam logic [3:0] IPF_OFS_CTRL2 = 4'h4;
	localparam logic [3:0] IPF_OFS_REQS = 4'h8;
	localparam logic [3:0] IPF_OFS_FWD = 4'hC;
	// field low bit positions
	localparam int IPF_POS_HI = 12;
	localparam int IPF_POS_MH = 8;
	localparam int IPF_POS_ML = 4;
	localparam int IPF_POS_LO = 0;
	localparam int IPF_NSRC = 8;
	// implemented bits of a priority register
	localparam logic [15:0] IPF_IMPL_MASK = 16'h7777;
	// every field resets to level 4, gaps to zero
	localparam logic [15:0] IPF_RESET_VAL = 16'h4444;
	localparam logic [2:0] IPF_LVL_OFF = 3'h0;
	localparam logic [1:0] IPF_RESP_OKAY = 2'h0;
	localparam logic [1:0] IPF_RESP_SLVERR = 2'h2;
	// one source's request and its level
	typedef struct packed {
		logic req;
		logic [2:0] level;
	} ipf_src_t;
endpackage : ipf_pkg

/* logic/ipf_prio_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module ipf_prio_reg
	import ipf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic [15:0] value
);
	logic [15:0] value_reg;
	logic [15:0] value_next;

	// byte lanes merge; gap bits masked so they never store
	always_comb begin
		value_next = value_reg;
		if (wstrb[0]) value_next[7:0] = wdata[7:0];
		if (wstrb[1]) value_next[15:8] = wdata[15:8];
		value_next = value_next & IPF_IMPL_MASK;
	end

	// fields load level 4 at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) value_reg <= IPF_RESET_VAL;
		else if (wr_en) value_reg <= value_next;
	end

	assign value = value_reg;

	gaps_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) (value_reg & ~IPF_IMPL_MASK) == 16'h0)
		else $error("unimplemented priority bit set");
	write_lands_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_en && wstrb[1] |=> value_reg[14:8] == ($past(wdata[14:8]) & IPF_IMPL_MASK[14:8]))
		else $error("high byte write not stored");
endmodule : ipf_prio_reg
`default_nettype wire

/* logic/ipf_src_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module ipf_src_gate
	import ipf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req_in,
	input wire logic [2:0] level,
	output ipf_src_t fwd
);
	ipf_src_t fwd_reg;

	// level 0 blocks the request; 1..7 pass with level equal to code
	always_ff @(posedge aclk) begin
		if (!aresetn) fwd_reg <= '0;
		else begin
			fwd_reg.req <= req_in && (level != IPF_LVL_OFF);
			fwd_reg.level <= level;
		end
	end

	assign fwd = fwd_reg;

	disabled_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(level) == IPF_LVL_OFF |-> !fwd_reg.req)
		else $error("disabled source forwarded");
	level_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(req_in) && $past(level) != 3'h0 |-> fwd_reg.req && fwd_reg.level == $past(level))
		else $error("enabled request lost or level wrong");
endmodule : ipf_src_gate
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
	import ipf_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [2:0] awprot, arprot;
	logic [31:0] wdata, rdata, got, d;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] src_req;
	ipf_src_t [7:0] src_fwd;
	logic [2:0] p_t2, p_oc2, p_ic2, p_dma0, p_u1rx, p_spi, p_spie, p_t3, lv;
	logic [15:0] sh1, sh2;
	logic [3:0] s;
	int err_total, n_compared, cyc;
	// live field ports in register order, timer2 first
	wire logic [23:0] live = {p_t2, p_oc2, p_ic2, p_dma0, p_u1rx, p_spi, p_spie, p_t3};

	ipf_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .src_req(src_req), .src_fwd(src_fwd), .timer2_prio(p_t2),
		.outcmp2_prio(p_oc2), .incap2_prio(p_ic2), .dma_ch0_done_prio(p_dma0), .uart1_rx_prio(p_u1rx),
		.spi1_event_prio(p_spi), .spi1_error_prio(p_spie), .timer3_prio(p_t3));

	always #20 aclk = ~aclk;

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] exp, input logic [31:0] act);
		n_compared++;
		if (act !== exp) begin
			err_total++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, act);
		end
	endtask : chk

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] dd, input logic [3:0] st, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= dd;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
	endtask : rd

	// lane strobes pick bytes, gap bits never stick
	function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] dd, input logic [3:0] st);
		logic [15:0] m;
		m = {{8{st[1]}}, {8{st[0]}}};
		return ((o & ~m) | (dd[15:0] & m)) & IPF_IMPL_MASK;
	endfunction : mrg

	function automatic logic [23:0] flds(input logic [15:0] a, input logic [15:0] b);
		return {a[14:12], a[10:8], a[6:4], a[2:0], b[14:12], b[10:8], b[6:4], b[2:0]};
	endfunction : flds

	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wstrb, awprot, arprot, wdata, src_req} = 58'h0;
		err_total = 0;
		n_compared = 0;
		cyc = 0;
		void'($urandom(32'h5CCC5AEF));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		sh1 = IPF_RESET_VAL;
		sh2 = IPF_RESET_VAL;
		rd(IPF_OFS_CTRL1, got, resp);
		chk({16'h0000, sh1}, got);
		rd(IPF_OFS_CTRL2, got, resp);
		chk({16'h0000, sh2}, got);
		chk({8'h00, flds(sh1, sh2)}, {8'h00, live});
		// random writes, the first two write ones to every bit including the gaps
		for (int i = 0; i < 24; i++) begin
			d = (i < 2) ? 32'hFFFFFFFF : $urandom();
			s = (i < 2) ? 4'hF : 4'($urandom());
			wr(i[0] ? IPF_OFS_CTRL2 : IPF_OFS_CTRL1, d, s, resp);
			chk({30'h0, IPF_RESP_OKAY}, {30'h0, resp});
			if (i[0]) sh2 = mrg(sh2, d, s);
			else sh1 = mrg(sh1, d, s);
			rd(i[0] ? IPF_OFS_CTRL2 : IPF_OFS_CTRL1, got, resp);
			chk({16'h0000, i[0] ? sh2 : sh1}, got);
			chk({8'h00, flds(sh1, sh2)}, {8'h00, live});
		end
		// write to a status place is refused, and ctrl1 reads back unchanged
		wr(IPF_OFS_REQS, 32'hFFFFFFFF, 4'hF, resp);
		chk({30'h0, IPF_RESP_SLVERR}, {30'h0, resp});
		rd(IPF_OFS_CTRL1, got, resp);
		chk({16'h0000, sh1}, got);
		// every code on every source, all requests set under code 0, random under each other code
		for (int c = 0; c < 8; c++) begin
			lv = c[2:0];
			d = {16'h0000, 1'b0, lv, 1'b0, lv, 1'b0, lv, 1'b0, lv};
			wr(IPF_OFS_CTRL1, d, 4'h3, resp);
			wr(IPF_OFS_CTRL2, d, 4'h3, resp);
			src_req <= (c == 0) ? 8'hFF : 8'($urandom());
			repeat (5) @(posedge aclk);
			for (int k = 0; k < 8; k++) chk({28'h0, src_req[k] && (lv != 3'h0), lv}, {28'h0, src_fwd[k]});
			rd(IPF_OFS_FWD, got, resp);
			chk({24'h0, (lv != 3'h0) ? src_req : 8'h00}, got);
			chk({30'h0, IPF_RESP_OKAY}, {30'h0, resp});
			rd(IPF_OFS_REQS, got, resp);
			chk({24'h0, src_req}, got);
		end
		finish_test();
	end
endmodule : tb
`default_nettype wire
